/* bmpe_consts.svh */
// Constants for the byte move / product execute slice of an 8-bit core.
// Assumes a single 100 MHz clock and byte-wide program and data memories.
// Summary of operation
// - Immediate to working register: two bytes, one cycle
// - Sum register to direct: two bytes, one cycle
// - Working register to direct: two cycles
// - Direct to direct: three bytes, source first
// - Indexed RAM to direct: two cycles
// - Bit copy uses carry; 1/2 cycles
// - Pointer load: high byte then low byte
// - Code read address is sum plus base
// - Counter base advanced before add; two cycles
// - Pointer-based code read keeps pointer unchanged
// - External reads into sum: two cycles
// - External writes of sum: two cycles
// - Product: low to sum, high to B, flags
// - Product is one byte, four cycles
// - Idle only advances the counter
// - Byte OR stores result, flags untouched
// - OR into direct on port reads output latch
// - OR into sum forms take one cycle
// - OR into direct: one or two cycles
// - Bit OR sets carry, source untouched
// - Bit OR forms: two bytes, two cycles
`ifndef BMPE_CONSTS_SVH
`define BMPE_CONSTS_SVH
`define BMPE_OP_IDLE 8'h00
`define BMPE_OP_MOV_RN_IMM 5'h0F
`define BMPE_OP_MOV_DIR_A 8'hF5
`define BMPE_OP_MOV_DIR_RN 5'h11
`define BMPE_OP_MOV_DIR_DIR 8'hE5
`define BMPE_OP_MOV_DIR_RI 7'h43
`define BMPE_OP_MOV_C_BIT 8'hA2
`define BMPE_OP_MOV_BIT_C 8'h92
`define BMPE_OP_MOV_DATA_POINTER 8'h90
`define BMPE_OP_CODE_PC 8'h83
`define BMPE_OP_CODE_DP 8'h93
`define BMPE_OP_XRD_RI 7'h71
`define BMPE_OP_XRD_DP 8'hE0
`define BMPE_OP_XWR_RI 7'h79
`define BMPE_OP_XWR_DP 8'hF0
`define BMPE_OP_MUL 8'hA4
`define BMPE_OP_OR_A_RN 5'h09
`define BMPE_OP_OR_A_DIR 8'h45
`define BMPE_OP_OR_A_RI 7'h23
`define BMPE_OP_OR_A_IMM 8'h44
`define BMPE_OP_OR_DIR_A 8'h42
`define BMPE_OP_OR_DIR_IMM 8'h43
`define BMPE_OP_OR_C_BIT 8'h72
`define BMPE_OP_OR_C_NBIT 8'hA0
`define BMPE_MUL_CYCLES 3'd4
`define BMPE_BYTE_MAX 16'h00FF
`define BMPE_ADDR_B 8'hF0
`define BMPE_ADDR_PSW 8'hD0
`define BMPE_ADDR_ACC 8'hE0
`define BMPE_ADDR_DPL 8'h82
`define BMPE_ADDR_DPH 8'h83
`define BMPE_PC_RESET 16'h0000
`endif

/* bmpe_exec.sv */
// Fetch, decode and execute for the copy, code read, external data,
// product, idle and OR instruction group.
// Assumes program memory answers combinationally on o_code_addr, and
// external data memory answers combinationally on o_xdata_addr.
`timescale 1ns/1ps
`include "bmpe_consts.svh"
module bmpe_exec (
    input wire logic i_clk,
    input wire logic i_rst_b,
    output logic [15:0] o_code_addr,
    input wire logic [7:0] i_code_data,
    output logic [15:0] o_xdata_addr,
    output logic o_xdata_we,
    output logic [7:0] o_xdata_wdata,
    input wire logic [7:0] i_xdata_rdata,
    input wire logic [7:0] i_port_pins,
    output logic [7:0] o_port_latch,
    output logic [15:0] o_pc,
    output logic [7:0] o_sum,
    output logic [7:0] o_breg,
    output logic [15:0] o_data_pointer,
    output bmpe_pkg::bmpe_flags_t o_flags,
    output logic o_insn_done,
    output logic o_illegal
);
    localparam logic [7:0] PORT_ADDR = 8'h90;

    typedef struct packed {
        bmpe_pkg::bmpe_state_t st;
        logic [15:0] pc;
        logic [7:0] op;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] acc;
        logic [7:0] breg;
        logic [15:0] data_pointer;
        logic carry;
        logic excess;
        logic [7:0] port;
        logic [7:0] pins_m1;
        logic [7:0] pins_m2;
        logic [7:0] pins_m3;
        logic [7:0] pins;
        logic done;
        logic illegal;
    } bmpe_exec_st_t;

    bmpe_exec_st_t s_q;
    bmpe_exec_st_t s_d;
    logic [7:0] iram [0:127];
    logic [7:0] iram_wdata;
    logic [6:0] iram_waddr;
    logic iram_we;
    logic mul_start;
    logic mul_done;
    bmpe_pkg::bmpe_prod_t mul_prod;
    logic [1:0] nbytes;
    logic cyc2;
    logic [2:0] rsel;

    ////////////////////////////////////////////////////////////////
    // Instruction length and whether a second cycle is needed
    always_comb begin
        nbytes = 2'd1;
        cyc2 = 1'b0;
        casez (s_q.op)
            8'b01111???: nbytes = 2'd2;
            `BMPE_OP_MOV_DIR_A: nbytes = 2'd2;
            8'b10001???: begin nbytes = 2'd2; cyc2 = 1'b1; end
            `BMPE_OP_MOV_DIR_DIR: nbytes = 2'd3;
            8'b1000011?: begin nbytes = 2'd2; cyc2 = 1'b1; end
            `BMPE_OP_MOV_C_BIT: nbytes = 2'd2;
            `BMPE_OP_MOV_BIT_C: begin nbytes = 2'd2; cyc2 = 1'b1; end
            `BMPE_OP_MOV_DATA_POINTER: begin nbytes = 2'd3; cyc2 = 1'b1; end
            `BMPE_OP_CODE_PC, `BMPE_OP_CODE_DP: cyc2 = 1'b1;
            8'b1110001?, `BMPE_OP_XRD_DP: cyc2 = 1'b1;
            8'b1111001?, `BMPE_OP_XWR_DP: cyc2 = 1'b1;
            `BMPE_OP_OR_A_DIR, `BMPE_OP_OR_A_IMM: nbytes = 2'd2;
            `BMPE_OP_OR_DIR_A: nbytes = 2'd2;
            `BMPE_OP_OR_DIR_IMM: begin nbytes = 2'd3; cyc2 = 1'b1; end
            `BMPE_OP_OR_C_BIT, `BMPE_OP_OR_C_NBIT: begin nbytes = 2'd2; cyc2 = 1'b1; end
            default: nbytes = 2'd1;
        endcase
    end

    // Special register read; ports read the output latch for OR into direct
    function automatic logic [7:0] rd_dir(input logic [7:0] a, input bmpe_exec_st_t s, input logic latch);
        logic [7:0] v;
        v = iram[a[6:0]];
        if (a[7]) begin
            case (a)
                `BMPE_ADDR_ACC: v = s.acc;
                `BMPE_ADDR_B: v = s.breg;
                `BMPE_ADDR_DPL: v = s.data_pointer[7:0];
                `BMPE_ADDR_DPH: v = s.data_pointer[15:8];
                `BMPE_ADDR_PSW: v = {s.carry, 4'h0, s.excess, 2'h0};
                PORT_ADDR: v = latch ? s.port : s.pins;
                default: v = 8'h00;
            endcase
        end
        return v;
    endfunction

    // Bit address to byte address; callers take the bit index from its low three bits
    function automatic logic [7:0] bit_byte(input logic [7:0] b);
        return b[7] ? {b[7:3], 3'h0} : {4'h2, b[6:3]};
    endfunction

    assign rsel = s_q.op[2:0];
    assign mul_start = (s_q.st == bmpe_pkg::BMPE_EXEC) && (s_q.op == `BMPE_OP_MUL);

    bmpe_mul #(
        .CYCLES(`BMPE_MUL_CYCLES - 1)
    ) u_mul (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_start(mul_start),
        .i_a(s_q.acc),
        .i_b(s_q.breg),
        .o_done(mul_done),
        .o_prod(mul_prod)
    );

    ////////////////////////////////////////////////////////////////
    // Sequencer and datapath
    always_comb begin
        logic [7:0] dst;
        logic [7:0] val;
        logic [7:0] byt;
        logic wr;
        logic bv;
        dst = 8'h00;
        val = 8'h00;
        byt = 8'h00;
        wr = 1'b0;
        bv = 1'b0;
        s_d = s_q;
        s_d.done = 1'b0;
        // Pins cross three stages; a value counts once stages two and three agree
        s_d.pins_m1 = i_port_pins;
        s_d.pins_m2 = s_q.pins_m1;
        s_d.pins_m3 = s_q.pins_m2;
        if (s_q.pins_m2 == s_q.pins_m3) begin
            s_d.pins = s_q.pins_m3;
        end
        o_code_addr = s_q.pc;
        o_xdata_addr = {8'h00, iram[{6'h00, s_q.op[0]}]};
        o_xdata_we = 1'b0;
        o_xdata_wdata = s_q.acc;
        case (s_q.st)
            // Opcode then operands, counter advancing past each
            bmpe_pkg::BMPE_FETCH: begin
                s_d.op = i_code_data;
                s_d.pc = s_q.pc + 16'h1;
                s_d.illegal = 1'b0;
                s_d.st = bmpe_pkg::BMPE_OPND1;
            end
            bmpe_pkg::BMPE_OPND1: begin
                if (nbytes == 2'd1) begin
                    s_d.st = bmpe_pkg::BMPE_EXEC;
                end else begin
                    s_d.b1 = i_code_data;
                    s_d.pc = s_q.pc + 16'h1;
                    s_d.st = (nbytes == 2'd3) ? bmpe_pkg::BMPE_OPND2 : bmpe_pkg::BMPE_EXEC;
                end
            end
            bmpe_pkg::BMPE_OPND2: begin
                s_d.b2 = i_code_data;
                s_d.pc = s_q.pc + 16'h1;
                s_d.st = bmpe_pkg::BMPE_EXEC;
            end
            bmpe_pkg::BMPE_EXEC: begin
                s_d.st = bmpe_pkg::BMPE_FETCH;
                s_d.done = 1'b1;
                casez (s_q.op)
                    `BMPE_OP_IDLE: s_d.done = 1'b1;
                    8'b01111???: begin dst = {5'h00, rsel}; val = s_q.b1; wr = 1'b1; end
                    `BMPE_OP_MOV_DIR_A: begin dst = s_q.b1; val = s_q.acc; wr = 1'b1; end
                    8'b10001???: begin dst = s_q.b1; val = iram[{4'h0, rsel}]; wr = 1'b1; end
                    `BMPE_OP_MOV_DIR_DIR: begin
                        dst = s_q.b2;
                        val = rd_dir(s_q.b1, s_q, 1'b0);
                        wr = 1'b1;
                    end
                    8'b1000011?: begin
                        dst = s_q.b1;
                        val = iram[iram[{6'h00, s_q.op[0]}][6:0]];
                        wr = 1'b1;
                    end
                    `BMPE_OP_MOV_C_BIT: begin
                        byt = rd_dir(bit_byte(s_q.b1), s_q, 1'b0);
                        s_d.carry = byt[s_q.b1[2:0]];
                    end
                    `BMPE_OP_MOV_BIT_C: begin
                        dst = bit_byte(s_q.b1);
                        val = rd_dir(dst, s_q, 1'b1);
                        val[s_q.b1[2:0]] = s_q.carry;
                        wr = 1'b1;
                    end
                    `BMPE_OP_MOV_DATA_POINTER: s_d.data_pointer = {s_q.b1, s_q.b2};
                    `BMPE_OP_CODE_PC: begin
                        o_code_addr = s_q.pc + {8'h00, s_q.acc};
                        s_d.acc = i_code_data;
                    end
                    `BMPE_OP_CODE_DP: begin
                        o_code_addr = s_q.data_pointer + {8'h00, s_q.acc};
                        s_d.acc = i_code_data;
                    end
                    8'b1110001?: s_d.acc = i_xdata_rdata;
                    `BMPE_OP_XRD_DP: begin
                        o_xdata_addr = s_q.data_pointer;
                        s_d.acc = i_xdata_rdata;
                    end
                    8'b1111001?: o_xdata_we = 1'b1;
                    `BMPE_OP_XWR_DP: begin
                        o_xdata_addr = s_q.data_pointer;
                        o_xdata_we = 1'b1;
                    end
                    `BMPE_OP_MUL: begin
                        s_d.st = bmpe_pkg::BMPE_WAIT;
                        s_d.done = 1'b0;
                    end
                    8'b01001???: s_d.acc = s_q.acc | iram[{4'h0, rsel}];
                    `BMPE_OP_OR_A_DIR: s_d.acc = s_q.acc | rd_dir(s_q.b1, s_q, 1'b0);
                    8'b0100011?: s_d.acc = s_q.acc | iram[iram[{6'h00, s_q.op[0]}][6:0]];
                    `BMPE_OP_OR_A_IMM: s_d.acc = s_q.acc | s_q.b1;
                    `BMPE_OP_OR_DIR_A: begin
                        dst = s_q.b1;
                        val = rd_dir(s_q.b1, s_q, 1'b1) | s_q.acc;
                        wr = 1'b1;
                    end
                    `BMPE_OP_OR_DIR_IMM: begin
                        dst = s_q.b1;
                        val = rd_dir(s_q.b1, s_q, 1'b1) | s_q.b2;
                        wr = 1'b1;
                    end
                    `BMPE_OP_OR_C_BIT, `BMPE_OP_OR_C_NBIT: begin
                        byt = rd_dir(bit_byte(s_q.b1), s_q, 1'b0);
                        bv = byt[s_q.b1[2:0]] ^ (s_q.op == `BMPE_OP_OR_C_NBIT);
                        s_d.carry = s_q.carry | bv;
                    end
                    default: s_d.illegal = 1'b1;
                endcase
                // Special register writes go to the state copy
                if (wr && dst[7]) begin
                    case (dst)
                        `BMPE_ADDR_ACC: s_d.acc = val;
                        `BMPE_ADDR_B: s_d.breg = val;
                        `BMPE_ADDR_DPL: s_d.data_pointer[7:0] = val;
                        `BMPE_ADDR_DPH: s_d.data_pointer[15:8] = val;
                        `BMPE_ADDR_PSW: begin
                            s_d.carry = val[7];
                            s_d.excess = val[2];
                        end
                        PORT_ADDR: s_d.port = val;
                        default: s_d.illegal = s_q.illegal;
                    endcase
                end
            end
            bmpe_pkg::BMPE_WAIT: begin
                if (mul_done) begin
                    s_d.acc = mul_prod.lo;
                    s_d.breg = mul_prod.hi;
                    s_d.excess = mul_prod.excess;
                    s_d.carry = 1'b0;
                    s_d.done = 1'b1;
                    s_d.st = bmpe_pkg::BMPE_FETCH;
                end
            end
            default: s_d.st = bmpe_pkg::BMPE_FETCH;
        endcase
        iram_we = wr && !dst[7];
        iram_waddr = dst[6:0];
        iram_wdata = val;
    end

    // State register; the counter restarts at its reset address
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            s_q <= '0;
            s_q.pc <= `BMPE_PC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Internal RAM, low half; reset leaves its contents alone
    always_ff @(posedge i_clk) begin
        if (iram_we) begin
            iram[iram_waddr] <= iram_wdata;
        end
    end

    assign o_pc = s_q.pc;
    assign o_sum = s_q.acc;
    assign o_breg = s_q.breg;
    assign o_data_pointer = s_q.data_pointer;
    assign o_flags = '{carry: s_q.carry, excess: s_q.excess};
    assign o_port_latch = s_q.port;
    assign o_insn_done = s_q.done;
    assign o_illegal = s_q.illegal;

    ////////////////////////////////////////////////////////////////
    // Checks
    property p_idle_pc;
        @(posedge i_clk) disable iff (!i_rst_b)
        (s_q.st == bmpe_pkg::BMPE_EXEC && s_q.op == `BMPE_OP_IDLE) |=> (s_q.pc == $past(s_q.pc) && s_q.acc == $past(s_q.acc));
    endproperty
    a_idle_pc: assert property (p_idle_pc) else $error("idle changed state");

    property p_mul_time;
        @(posedge i_clk) disable iff (!i_rst_b)
        mul_start |-> ##3 (mul_done && s_q.st == bmpe_pkg::BMPE_WAIT);
    endproperty
    a_mul_time: assert property (p_mul_time) else $error("product latency wrong");

    property p_mul_flags;
        @(posedge i_clk) disable iff (!i_rst_b)
        (s_q.st == bmpe_pkg::BMPE_WAIT && mul_done) |=> (!s_q.carry && s_q.excess == (s_q.breg != 8'h00));
    endproperty
    a_mul_flags: assert property (p_mul_flags) else $error("product flags wrong");

    property p_data_pointer_load;
        @(posedge i_clk) disable iff (!i_rst_b)
        (s_q.st == bmpe_pkg::BMPE_EXEC && s_q.op == `BMPE_OP_MOV_DATA_POINTER) |=> (s_q.data_pointer == {$past(s_q.b1), $past(s_q.b2)});
    endproperty
    a_data_pointer_load: assert property (p_data_pointer_load) else $error("pointer load order wrong");

    property p_code_dp;
        @(posedge i_clk) disable iff (!i_rst_b)
        (s_q.st == bmpe_pkg::BMPE_EXEC && s_q.op == `BMPE_OP_CODE_DP) |-> (o_code_addr == s_q.data_pointer + {8'h00, s_q.acc}) ##1 $stable(s_q.data_pointer);
    endproperty
    a_code_dp: assert property (p_code_dp) else $error("code read address wrong");

    property p_or_acc;
        @(posedge i_clk) disable iff (!i_rst_b)
        (s_q.st == bmpe_pkg::BMPE_EXEC && s_q.op == `BMPE_OP_OR_A_IMM) |=> (s_q.acc == ($past(s_q.acc) | $past(s_q.b1)) && $stable(s_q.carry));
    endproperty
    a_or_acc: assert property (p_or_acc) else $error("OR immediate wrong");

    property p_or_carry;
        @(posedge i_clk) disable iff (!i_rst_b)
        (s_q.st == bmpe_pkg::BMPE_EXEC && (s_q.op == `BMPE_OP_OR_C_BIT || s_q.op == `BMPE_OP_OR_C_NBIT) && s_q.carry) |=> s_q.carry;
    endproperty
    a_or_carry: assert property (p_or_carry) else $error("bit OR cleared carry");

    property p_xwrite;
        @(posedge i_clk) disable iff (!i_rst_b)
        o_xdata_we |-> (s_q.st == bmpe_pkg::BMPE_EXEC && o_xdata_wdata == s_q.acc && cyc2);
    endproperty
    a_xwrite: assert property (p_xwrite) else $error("external write misplaced");

    property p_fetch_pc;
        @(posedge i_clk) disable iff (!i_rst_b)
        (s_q.st == bmpe_pkg::BMPE_FETCH) |=> (s_q.pc == $past(s_q.pc) + 16'h1);
    endproperty
    a_fetch_pc: assert property (p_fetch_pc) else $error("opcode fetch did not advance");
endmodule : bmpe_exec

/* bmpe_mem_model.sv */
// Program memory and external data memory model for the execute slice.
// Assumes the core reads both memories combinationally, writes on the edge.
`timescale 1ns/1ps
module bmpe_mem_model (
    input wire logic i_clk,
    input wire logic [15:0] i_code_addr,
    output logic [7:0] o_code_data,
    input wire logic [15:0] i_xdata_addr,
    input wire logic i_xdata_we,
    input wire logic [7:0] i_xdata_wdata,
    output logic [7:0] o_xdata_rdata
);
    logic [7:0] code_mem [0:65535];
    logic [7:0] xdata_mem [0:65535];

    ////////////////////////////////////////////////////////////////////////
    // Same-cycle answers; unwritten places read unknown on purpose
    assign o_code_data = code_mem[i_code_addr];
    assign o_xdata_rdata = xdata_mem[i_xdata_addr];

    // Write strobe is a one-cycle pulse, taken at the rising edge
    always @(posedge i_clk) begin
        if (i_xdata_we === 1'b1) begin
            xdata_mem[i_xdata_addr] <= i_xdata_wdata;
        end
    end
endmodule : bmpe_mem_model

/* bmpe_mul.sv */
// Unsigned 8x8 multiplier with a fixed latency, started by a pulse.
// Assumes operands are stable from the start pulse.
`timescale 1ns/1ps
`include "bmpe_consts.svh"
module bmpe_mul #(
    parameter int CYCLES = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_start,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    output logic o_done,
    output bmpe_pkg::bmpe_prod_t o_prod
);
    typedef struct packed {
        logic [2:0] cnt;
        logic busy;
        logic done;
        bmpe_pkg::bmpe_prod_t prod;
    } bmpe_mul_st_t;

    bmpe_mul_st_t s_q;
    bmpe_mul_st_t s_d;
    logic [15:0] full;

    initial begin
        if (CYCLES < 2 || CYCLES > 7) $error("bmpe_mul: CYCLES out of range");
    end

    assign full = 16'(i_a) * 16'(i_b);

    ////////////////////////////////////////////////////////////////
    // Counts down, then pulses done for one cycle; the product is held after
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (i_start) begin
            s_d.busy = 1'b1;
            s_d.cnt = 3'(CYCLES - 2);
        end else if (s_q.busy) begin
            if (s_q.cnt == 3'h0) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.prod.lo = full[7:0];
                s_d.prod.hi = full[15:8];
                s_d.prod.excess = (full > `BMPE_BYTE_MAX);
            end else begin
                s_d.cnt = s_q.cnt - 3'h1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_done = s_q.done;
    assign o_prod = s_q.prod;
endmodule : bmpe_mul

/* bmpe_pkg.sv */
// Types shared by the execute slice and its multiplier.
// Assumes the constants header is included by the users.
package bmpe_pkg;
    typedef enum logic [2:0] {
        BMPE_FETCH,
        BMPE_OPND1,
        BMPE_OPND2,
        BMPE_EXEC,
        BMPE_WAIT
    } bmpe_state_t;

    typedef struct packed {
        logic carry;
        logic excess;
    } bmpe_flags_t;

    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic excess;
    } bmpe_prod_t;
endpackage : bmpe_pkg

/* tb_top.sv */
// Self-checking bench for the execute slice: runs short programs.
// Assumes the memory model stands on the far side of both memory buses.
`timescale 1ns/1ps
module tb_top;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] i_port_pins = 8'hFF;
    logic [15:0] code_addr;
    logic [7:0] code_data;
    logic [15:0] xdata_addr;
    logic xdata_we;
    logic [7:0] xdata_wdata;
    logic [7:0] xdata_rdata;
    logic [7:0] port_latch;
    logic [15:0] pc;
    logic [7:0] sum;
    logic [7:0] breg;
    logic [15:0] data_pointer;
    bmpe_pkg::bmpe_flags_t flags;
    logic insn_done;
    logic illegal;
    int mismatches = 0;
    int tests_run = 0;

    ////////////////////////////////////////////////////////////////////////
    bmpe_exec bmpe_exec_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .o_code_addr(code_addr),
        .i_code_data(code_data), .o_xdata_addr(xdata_addr), .o_xdata_we(xdata_we),
        .o_xdata_wdata(xdata_wdata), .i_xdata_rdata(xdata_rdata), .i_port_pins(i_port_pins),
        .o_port_latch(port_latch), .o_pc(pc), .o_sum(sum), .o_breg(breg), .o_data_pointer(data_pointer),
        .o_flags(flags), .o_insn_done(insn_done), .o_illegal(illegal));
    bmpe_mem_model bmpe_mem_model_inst (.i_clk(i_clk), .i_code_addr(code_addr),
        .o_code_data(code_data), .i_xdata_addr(xdata_addr), .i_xdata_we(xdata_we),
        .i_xdata_wdata(xdata_wdata), .o_xdata_rdata(xdata_rdata));

    // 100 MHz clock
    initial begin
        forever #5 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic conclude();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // Program from address 0, idle bytes after it; reset held 6 cycles
    task automatic start(input logic [7:0] p []);
        for (int i = 0; i < 64; i++) begin
            bmpe_mem_model_inst.code_mem[i] = (i < p.size()) ? p[i] : 8'h00;
        end
        @(posedge i_clk);
        #1 i_rst_b = 1'b0;
        repeat (6) @(posedge i_clk);
        chk("reset pc", 16'h0000, pc);
        chk("reset sum", 16'h0000, {8'h00, sum});
        chk("reset data_pointer", 16'h0000, data_pointer);
        #1 i_rst_b = 1'b1;
    endtask : start

    // Registers are sampled in the done cycle, before the next exec lands
    task automatic run(input int n);
        int seen;
        int cyc;
        seen = 0;
        cyc = 0;
        while (seen < n) begin
            @(posedge i_clk);
            #1;
            cyc++;
            if (insn_done === 1'b1) seen++;
            if (cyc > 40 * n) begin
                mismatches++;
                $display("CHECK FAILED insn_done count expected %0d seen %0d", n, seen);
                conclude();
            end
        end
    endtask : run

    ////////////////////////////////////////////////////////////////////////
    // Pointer load with low-byte carry, table read, external write and read
    task automatic s_pointer();
        bmpe_mem_model_inst.code_mem[16'h1304] = 8'h5A;
        bmpe_mem_model_inst.xdata_mem[16'h12FF] = 8'h00;
        start('{8'h90, 8'h12, 8'hFF, 8'h44, 8'h05, 8'h93, 8'hF0, 8'h44, 8'h80, 8'hE0});
        run(1);
        chk("data_pointer load", 16'h12FF, data_pointer);
        run(2);
        chk("code read", 16'h005A, {8'h00, sum});
        chk("data_pointer kept", 16'h12FF, data_pointer);
        run(1);
        chk("xdata write", 16'h005A, {8'h00, bmpe_mem_model_inst.xdata_mem[16'h12FF]});
        run(2);
        chk("xdata read", 16'h005A, {8'h00, sum});
    endtask : s_pointer

    // Product with overflow, then without; carry set beforehand
    task automatic s_product();
        start('{8'h44, 8'hA0, 8'hF5, 8'hF0, 8'hA2, 8'hE7, 8'h78, 8'h50, 8'h88, 8'hE0, 8'hA4,
            8'h44, 8'h02, 8'hA4});
        run(3);
        chk("b from sum", 16'h00A0, {8'h00, breg});
        chk("carry from bit", 16'h0001, {15'h0000, flags.carry});
        run(2);
        chk("sum from reg", 16'h0050, {8'h00, sum});
        run(1);
        chk("product", 16'h3200, {breg, sum});
        chk("flags ovf", 16'h0001, {14'h0000, flags.carry, flags.excess});
        run(2);
        chk("product 2", 16'h0064, {breg, sum});
        chk("flags 2", 16'h0000, {14'h0000, flags.carry, flags.excess});
    endtask : s_product

    // Idle, pc-based table read, OR into port latch, sum and carry
    task automatic s_or();
        start('{8'h44, 8'h20, 8'h00, 8'h00, 8'h83, 8'h43, 8'h90, 8'h32, 8'h42, 8'h90, 8'h78,
            8'h0C, 8'h48, 8'h72, 8'hE4, 8'hA0, 8'hE5, 8'h92, 8'hF0});
        // Table byte placed after loading, which clears the low code area
        bmpe_mem_model_inst.code_mem[16'h0025] = 8'hC3;
        run(4);
        chk("pc table read", 16'h00C3, {8'h00, sum});
        run(1);
        chk("or imm port", 16'h0032, {8'h00, port_latch});
        run(1);
        chk("or sum port", 16'h00F3, {8'h00, port_latch});
        run(2);
        chk("or reg", 16'h00CF, {8'h00, sum});
        run(1);
        chk("or bit zero", 16'h0000, {15'h0000, flags.carry});
        run(1);
        chk("or nbit", 16'h0001, {15'h0000, flags.carry});
        chk("src kept", 16'h00CF, {8'h00, sum});
        run(1);
        chk("bit from carry", 16'h0001, {8'h00, breg});
    endtask : s_or

    // Direct and indirect copies through RAM, then an opcode outside the group
    task automatic s_copy();
        int k;
        start('{8'h44, 8'h12, 8'hF5, 8'h30, 8'hE5, 8'h30, 8'h40, 8'h78, 8'h40, 8'h86, 8'h50,
            8'h7A, 8'h00, 8'h8A, 8'hE0, 8'h45, 8'h40, 8'h8A, 8'hE0, 8'h79, 8'h50, 8'h47, 8'h04});
        run(8);
        chk("dir to dir", 16'h0012, {8'h00, sum});
        run(4);
        chk("indirect", 16'h0012, {8'h00, sum});
        k = 0;
        while (illegal !== 1'b1 && k < 20) begin
            @(posedge i_clk);
            #1;
            k++;
        end
        chk("illegal", 16'h0001, {15'h0000, illegal});
    endtask : s_copy

    ////////////////////////////////////////////////////////////////////////
    initial begin
        s_pointer();
        s_product();
        s_or();
        s_copy();
        conclude();
    end
endmodule : tb_top
